/* exec_pkg.sv */
`default_nettype none
package exec_pkg;
    // Register word offsets on the APB bus.
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_INSTR = 8'h04;
    localparam logic [7:0] ADDR_BC    = 8'h08;
    localparam logic [7:0] ADDR_DE    = 8'h0C;
    localparam logic [7:0] ADDR_MP    = 8'h10;
    localparam logic [7:0] ADDR_AF    = 8'h14;
    localparam logic [7:0] ADDR_STACK = 8'h18;
    localparam logic [7:0] ADDR_IDX1  = 8'h1C;
    localparam logic [7:0] ADDR_IDX2  = 8'h20;
    localparam logic [7:0] ADDR_PC    = 8'h24;

    // Control and status bit positions.
    localparam int CTRL_GO   = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int STAT_BRK  = 2;
    localparam int STAT_BAD  = 3;

    // Flag positions in the flag byte.
    localparam int FLAG_ZERO = 6;
    localparam int FLAG_SUB  = 1;

    localparam logic [15:0] REG_RESET = 16'h0000;

    // Opcode bytes.
    localparam logic [7:0] PFX_ED      = 8'hED;
    localparam logic [7:0] PFX_IDX1    = 8'hDD;
    localparam logic [7:0] PFX_IDX2    = 8'hFD;
    localparam logic [7:0] OPC_POP     = 8'hE1;
    localparam logic [7:0] OPC_OUT_N   = 8'hD3;
    localparam logic [7:0] OPC_STEP_UP = 8'hA3;
    localparam logic [7:0] OPC_STEP_DN = 8'hAB;
    localparam logic [7:0] OPC_REP_UP  = 8'hB3;
    localparam logic [7:0] OPC_REP_DN  = 8'hBB;
    localparam logic [7:0] OUT_C_MASK  = 8'hC7;
    localparam logic [7:0] OUT_C_CODE  = 8'h41;
    localparam logic [2:0] SRC_NONE    = 3'b110;

    // T states per machine cycle.
    localparam logic [2:0] T_FETCH      = 3'd4;
    localparam logic [2:0] T_FETCH_LONG = 3'd5;
    localparam logic [2:0] T_MEM_RD     = 3'd3;
    localparam logic [2:0] T_IO_WR      = 3'd4;
    localparam logic [2:0] T_TAIL       = 3'd5;
    localparam logic [2:0] T_OPERAND    = 3'd3;

    // Clock cycles per T state and instruction length in bytes.
    localparam int          T_CLK_DIV  = 4;
    localparam logic [15:0] INSTR_LEN  = 16'h0002;

    typedef enum {op_none, op_blk, op_out_c, op_out_n, op_pop} op_e;
endpackage : exec_pkg
`default_nettype wire

/* tstate_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Divides pclk into T-state ticks and marks the last tick of each machine cycle.
module tstate_seq #(
    parameter int DIV   = 4,
    parameter int DIV_W = 8
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic [2:0] m_len,
    output logic            t_tick,
    output logic            m_end
);
    logic [DIV_W-1:0] div_cnt;
    logic [2:0]       t_num;

    assign t_tick = run && (div_cnt == DIV_W'(DIV - 1));
    assign m_end  = t_tick && (t_num == m_len - 3'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            t_num   <= 3'd0;
        end else if (!run) begin
            div_cnt <= '0;
            t_num   <= 3'd0;
        end else begin
            div_cnt <= t_tick ? '0 : div_cnt + 1'b1;
            if (t_tick) begin
                t_num <= m_end ? 3'd0 : t_num + 3'd1;
            end
        end
    end
endmodule : tstate_seq
`default_nettype wire

/* io_out_pop_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Block and step output first read the byte at the memory pointer and hold it.
// - Byte count high byte decrements before the port write; address is {count, port}.
// - Repeat-up bumps the pointer; repeats while count nonzero, else finishes.
// - A count of zero wraps, so a repeat moves 256 bytes.
// - Interrupts accepted and two refresh cycles run between repeat iterations.
// - A repeating up iteration takes 5 machine cycles, 21 T states (4,5,3,4,5).
// - The last repeat iteration takes 4 machine cycles, 16 T states (4,5,3,4).
// - Repeat completion sets zero and subtract flags; others left as they were.
// - Step output sets zero when count reaches zero, sets subtract.
// - Step-down (ED AB) writes one port byte, then lowers the pointer.
// - Step output takes 4 machine cycles, 16 T states, and never repeats.
// - Register output drives {count, port} and writes the chosen register.
// - Source field: 000 B, 001 C, 010 D, 011 E, 100 H, 101 L, 111 A.
// - Register output takes 3 machine cycles, 12 T states, flags untouched.
// - Immediate output drives {accumulator, operand} and writes the accumulator.
// - Immediate output takes 3 machine cycles, 11 T states, flags untouched.
// - Index pull reads low at stack top, bumps pointer, reads high, bumps again.
// - The second index pull (FD E1) uses the same low then high order.
// - Index pull takes 4 machine cycles, 14 T states (4,4,3,3), flags untouched.
// - Repeat-down lowers the pointer after each write, repeats while count nonzero.
// - A repeating down iteration takes 5 machine cycles, 21 T states.
module io_out_pop_exec #(
    parameter int T_DIV = exec_pkg::T_CLK_DIV
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    output logic [15:0]      bus_addr,
    output logic [7:0]       bus_dout,
    input  wire logic [7:0]  bus_din,
    output logic             mem_rd,
    output logic             io_wr,
    output logic             refresh,
    output logic [6:0]       refresh_row,
    input  wire logic        int_req,
    output logic             int_ack
);
    import exec_pkg::*;

    typedef enum {st_idle, st_run} run_state_e;

    run_state_e  state;
    op_e         op;
    logic [2:0]  m_idx;
    logic        step_down;
    logic        step_repeat;
    logic        pull_second;
    logic [2:0]  src_sel;
    logic [7:0]  port_imm;
    logic [7:0]  xfer;
    logic [15:0] instr;
    logic [15:0] bc;
    logic [15:0] de;
    logic [15:0] memory_pointer_pair;
    logic [15:0] af;
    logic [15:0] stack_top_pointer;
    logic [15:0] first_index_pointer;
    logic [15:0] second_index_pointer;
    logic [15:0] program_counter;
    logic        done;
    logic        brk;
    logic        bad;
    logic        int_s1;
    logic        int_s2;

    // Instruction decode from the staged opcode bytes.
    wire [7:0] first_byte  = instr[7:0];
    wire [7:0] second_byte = instr[15:8];
    wire dec_blk = first_byte == PFX_ED &&
                   (second_byte == OPC_STEP_UP || second_byte == OPC_STEP_DN ||
                    second_byte == OPC_REP_UP || second_byte == OPC_REP_DN);
    wire dec_out_c = first_byte == PFX_ED && (second_byte & OUT_C_MASK) == OUT_C_CODE &&
                     second_byte[5:3] != SRC_NONE;
    wire dec_out_n = first_byte == OPC_OUT_N;
    wire dec_pop = (first_byte == PFX_IDX1 || first_byte == PFX_IDX2) && second_byte == OPC_POP;
    op_e dec_op;
    assign dec_op = dec_blk ? op_blk : dec_out_c ? op_out_c : dec_out_n ? op_out_n :
                    dec_pop ? op_pop : op_none;

    // APB decode.
    wire apb_setup  = psel && !penable;
    wire apb_wr     = psel && penable && pready && pwrite;
    wire hit_ctrl   = paddr == ADDR_CTRL;
    wire hit_instr  = paddr == ADDR_INSTR;
    wire hit_bc     = paddr == ADDR_BC;
    wire hit_de     = paddr == ADDR_DE;
    wire hit_mp     = paddr == ADDR_MP;
    wire hit_af     = paddr == ADDR_AF;
    wire hit_stack  = paddr == ADDR_STACK;
    wire hit_idx1   = paddr == ADDR_IDX1;
    wire hit_idx2   = paddr == ADDR_IDX2;
    wire hit_pc     = paddr == ADDR_PC;
    wire mapped     = hit_ctrl | hit_instr | hit_bc | hit_de | hit_mp | hit_af |
                      hit_stack | hit_idx1 | hit_idx2 | hit_pc;
    wire run        = state == st_run;
    wire reg_wr     = apb_wr && !run;
    wire ctrl_wr    = apb_wr && hit_ctrl;
    wire go_req     = ctrl_wr && pwdata[CTRL_GO] && !run;
    wire start      = go_req && dec_op != op_none;
    wire reject     = go_req && dec_op == op_none;

    wire [31:0] rd_word =
        hit_ctrl  ? {28'h000_0000, bad, brk, done, run} :
        hit_instr ? {16'h0000, instr} :
        hit_bc    ? {16'h0000, bc} :
        hit_de    ? {16'h0000, de} :
        hit_mp    ? {16'h0000, memory_pointer_pair} :
        hit_af    ? {16'h0000, af} :
        hit_stack ? {16'h0000, stack_top_pointer} :
        hit_idx1  ? {16'h0000, first_index_pointer} :
        hit_idx2  ? {16'h0000, second_index_pointer} :
        hit_pc    ? {16'h0000, program_counter} : 32'h0000_0000;

    // Machine cycle lengths per instruction and cycle index.
    // Repeat iteration lengths.
    wire [2:0] len_blk = m_idx == 3'd0 ? T_FETCH : m_idx == 3'd1 ? T_FETCH_LONG :
                         m_idx == 3'd2 ? T_MEM_RD : m_idx == 3'd3 ? T_IO_WR : T_TAIL;
    wire [2:0] len_n   = m_idx == 3'd1 ? T_OPERAND : m_idx == 3'd2 ? T_IO_WR : T_FETCH;
    wire [2:0] len_pop = m_idx < 3'd2 ? T_FETCH : T_MEM_RD;
    wire [2:0] len_c   = m_idx == 3'd2 ? T_IO_WR : T_FETCH;
    wire [2:0] m_len   = op == op_blk ? len_blk : op == op_out_n ? len_n :
                         op == op_pop ? len_pop : len_c;
    wire       m_end;

    tstate_seq #(
        .DIV   (T_DIV),
        .DIV_W (8)
    ) u_seq (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (run),
        .m_len   (m_len),
        .t_tick  (),
        .m_end   (m_end)
    );

    wire [7:0] src_byte = src_sel == 3'b000 ? bc[15:8] :
                          src_sel == 3'b001 ? bc[7:0] :
                          src_sel == 3'b010 ? de[15:8] :
                          src_sel == 3'b011 ? de[7:0] :
                          src_sel == 3'b100 ? memory_pointer_pair[15:8] :
                          src_sel == 3'b101 ? memory_pointer_pair[7:0] : af[15:8];

    wire is_out   = op == op_out_c || op == op_out_n;
    // Memory read cycle at the pointer.
    wire rd_cycle = run && ((op == op_blk && m_idx == 3'd2) || (op == op_pop && m_idx >= 3'd2));
    wire wr_cycle = run && ((op == op_blk && m_idx == 3'd3) || (is_out && m_idx == 3'd2));
    wire [15:0] rd_addr = op == op_pop ? stack_top_pointer : memory_pointer_pair;
    wire [15:0] wr_addr = op == op_out_n ? {af[15:8], port_imm} : bc;
    wire [7:0]  wr_data = op == op_blk ? xfer : op == op_out_n ? af[15:8] : src_byte;

    wire dec_end  = m_end && op == op_blk && m_idx == 3'd1;
    wire rd_end   = m_end && rd_cycle;
    wire xfer_end = m_end && op == op_blk && m_idx == 3'd3;
    wire tail_end = m_end && op == op_blk && m_idx == 3'd4;
    wire more     = step_repeat && bc[15:8] != 8'h00;
    wire finish   = (xfer_end && !more) || (m_end && is_out && m_idx == 3'd2) ||
                    (m_end && op == op_pop && m_idx == 3'd3);
    wire brk_take = tail_end && int_s2;
    wire [15:0] ptr_step = step_down ? memory_pointer_pair - 16'h0001 :
                                       memory_pointer_pair + 16'h0001;
    wire [15:0] sp_inc   = stack_top_pointer + 16'h0001;
    wire [15:0] pulled   = {bus_din, xfer};

    // Interrupt request pin synchroniser.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_s1 <= 1'b0;
            int_s2 <= 1'b0;
        end else begin
            int_s1 <= int_req;
            int_s2 <= int_s1;
        end
    end

    // Sequencer state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= st_idle;
            op          <= op_none;
            m_idx       <= 3'd0;
            step_down   <= 1'b0;
            step_repeat <= 1'b0;
            pull_second <= 1'b0;
            src_sel     <= 3'd0;
            port_imm    <= 8'h00;
        end else if (start) begin
            state       <= st_run;
            op          <= dec_op;
            m_idx       <= 3'd0;
            step_down   <= second_byte[3];
            step_repeat <= second_byte[4];
            pull_second <= first_byte == PFX_IDX2;
            src_sel     <= second_byte[5:3];
            port_imm    <= second_byte;
        end else if (finish || brk_take) begin
            state <= st_idle;
            m_idx <= 3'd0;
        end else if (tail_end) begin
            // Only a repeating pass runs the fifth cycle.
            m_idx <= 3'd0;
        end else if (m_end) begin
            m_idx <= m_idx + 3'd1;
        end
    end

    // Sticky status: a hardware set wins over a software clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            brk  <= 1'b0;
            bad  <= 1'b0;
        end else begin
            done <= finish || (done && !(ctrl_wr && pwdata[STAT_DONE]));
            brk  <= brk_take || (brk && !(ctrl_wr && pwdata[STAT_BRK]));
            bad  <= reject || (bad && !(ctrl_wr && pwdata[STAT_BAD]));
        end
    end

    // Byte counter, pointer and flags.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bc                  <= REG_RESET;
            memory_pointer_pair <= REG_RESET;
            af                  <= REG_RESET;
            xfer                <= 8'h00;
        end else if (run) begin
            if (dec_end) begin
                // Count drops before the write, wrapping at zero.
                bc[15:8] <= bc[15:8] - 8'h01;
            end
            if (rd_end) begin
                xfer <= bus_din;
            end
            if (xfer_end) begin
                memory_pointer_pair <= ptr_step;
                // Zero tracks the count, subtract set.
                af[FLAG_ZERO] <= bc[15:8] == 8'h00;
                af[FLAG_SUB]  <= 1'b1;
            end
        end else if (reg_wr) begin
            if (hit_bc) bc <= pwdata[15:0];
            if (hit_mp) memory_pointer_pair <= pwdata[15:0];
            if (hit_af) af <= pwdata[15:0];
        end
    end

    // Stack, index and program counter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            de                   <= REG_RESET;
            stack_top_pointer    <= REG_RESET;
            first_index_pointer  <= REG_RESET;
            second_index_pointer <= REG_RESET;
            program_counter      <= REG_RESET;
            instr                <= REG_RESET;
        end else if (run) begin
            // Each pull read bumps the stack top.
            if (rd_end && op == op_pop) begin
                stack_top_pointer <= sp_inc;
            end
            // High byte lands last in the selected index.
            if (finish && op == op_pop && !pull_second) first_index_pointer <= pulled;
            if (finish && op == op_pop && pull_second) second_index_pointer <= pulled;
            // A repeat or break keeps the counter on the instruction.
            if (finish) begin
                program_counter <= program_counter + INSTR_LEN;
            end
        end else if (reg_wr) begin
            if (hit_de) de <= pwdata[15:0];
            if (hit_stack) stack_top_pointer <= pwdata[15:0];
            if (hit_idx1) first_index_pointer <= pwdata[15:0];
            if (hit_idx2) second_index_pointer <= pwdata[15:0];
            if (hit_pc) program_counter <= pwdata[15:0];
            if (hit_instr) instr <= pwdata[15:0];
        end
    end

    // External bus strobes, registered.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_addr <= REG_RESET;
            bus_dout <= 8'h00;
            mem_rd   <= 1'b0;
            io_wr    <= 1'b0;
        end else begin
            bus_addr <= rd_cycle ? rd_addr : wr_cycle ? wr_addr : REG_RESET;
            bus_dout <= wr_cycle ? wr_data : 8'h00;
            mem_rd   <= rd_cycle;
            io_wr    <= wr_cycle;
        end
    end

    // Refresh after each of the first two machine cycles, and interrupt acknowledge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh     <= 1'b0;
            refresh_row <= 7'h00;
            int_ack     <= 1'b0;
        end else begin
            refresh <= run && m_end && m_idx < 3'd2;
            if (run && m_end && m_idx < 3'd2) begin
                refresh_row <= refresh_row + 7'h01;
            end
            int_ack <= brk_take;
        end
    end

    // APB slave with one access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            prdata  <= apb_setup && !pwrite ? rd_word : 32'h0000_0000;
            pslverr <= apb_setup && !mapped;
        end
    end
endmodule : io_out_pop_exec
`default_nettype wire

/* io_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module io_bus_model (
    input  wire logic        pclk,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_dout,
    input  wire logic        mem_rd,
    input  wire logic        io_wr,
    input  wire logic        refresh,
    output logic [7:0]       bus_din
);
    logic [23:0] wq[$];
    int          wt[$];
    int          mt[$];
    int          cyc = 0;
    int          nref = 0;
    logic        wr_q = 1'b0;
    logic        rd_q = 1'b0;
    logic [7:0]  idle = 8'h00;

    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'hA5;
    endfunction : byte_at

    // Outside a read the data lines toggle every cycle, so a late sample never passes.
    assign bus_din = mem_rd ? byte_at(bus_addr) : idle;

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        idle <= ~idle;
        wr_q <= io_wr;
        rd_q <= mem_rd;
        if (refresh === 1'b1) nref <= nref + 1;
        if (io_wr === 1'b1 && !wr_q) begin
            wq.push_back({bus_addr, bus_dout});
            wt.push_back(cyc);
        end
        if (mem_rd === 1'b1 && !rd_q) mt.push_back(cyc);
    end
endmodule : io_bus_model
`default_nettype wire

/* io_out_pop_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module io_out_pop_exec_checker #(
    parameter int T_DIV = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_dout,
    input  wire logic        mem_rd,
    input  wire logic        io_wr,
    input  wire logic        refresh,
    input  wire logic [6:0]  refresh_row,
    input  wire logic        int_ack
);
    logic [9:0] rd_len;
    logic [9:0] wr_len;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_len <= '0;
            wr_len <= '0;
        end else begin
            rd_len <= mem_rd ? rd_len + 10'd1 : 10'd0;
            wr_len <= io_wr ? wr_len + 10'd1 : 10'd0;
        end
    end

    a_no_overlap: assert property (!(mem_rd && io_wr))
        else $error("Memory read overlaps a port write.");
    a_read_len: assert property ($fell(mem_rd) |-> rd_len == 10'(3*T_DIV) || rd_len == 10'(6*T_DIV))
        else $error("Memory read has a wrong length.");
    a_write_len: assert property ($fell(io_wr) |-> wr_len == 10'(4*T_DIV))
        else $error("Port write has a wrong length.");
    a_write_hold: assert property (io_wr && $past(io_wr) |-> $stable(bus_addr) && $stable(bus_dout))
        else $error("Port write address or data moved.");
    a_dout_idle: assert property (!io_wr |-> bus_dout == 8'h00)
        else $error("Data driven outside a port write.");
    a_refresh_pulse: assert property (refresh |=> !refresh)
        else $error("Refresh pulse too long.");
    a_row_moves: assert property ($changed(refresh_row) |-> refresh || $past(refresh))
        else $error("Refresh row moved without a refresh.");
    a_ack_pulse: assert property (int_ack |=> !int_ack)
        else $error("Break acknowledge too long.");
    a_ack_quiet: assert property (int_ack |=> (!io_wr && !mem_rd) [*4])
        else $error("Bus activity after a break.");

    c_write: cover property ($rose(io_wr));
    c_pull: cover property ($fell(mem_rd) && rd_len == 10'(6*T_DIV));
    c_break: cover property (int_ack);
endmodule : io_out_pop_exec_checker

bind io_out_pop_exec io_out_pop_exec_checker #(.T_DIV(T_DIV)) chk (
    .pclk(pclk), .presetn(presetn), .bus_addr(bus_addr), .bus_dout(bus_dout), .mem_rd(mem_rd),
    .io_wr(io_wr), .refresh(refresh), .refresh_row(refresh_row), .int_ack(int_ack)
);
`default_nettype wire

/* test_io_out_pop_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module test_io_out_pop_exec;
    import exec_pkg::*;
    localparam int TD = 1;
    typedef struct {
        logic [15:0] ins, bc, mp, sp, ebc, er, wa;
        logic [7:0]  ra, ef, fm, wd;
        int          nw, stp;
    } row_s;

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        int_req = 1'b0;
    logic        pready, pslverr, mem_rd, io_wr, refresh, int_ack;
    logic [31:0] prdata;
    logic [15:0] bus_addr;
    logic [7:0]  bus_dout, bus_din;
    logic [6:0]  refresh_row;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    int          n_ack = 0;
    row_s        rows[8] = '{
        '{16'hA3ED, 16'h1007, 16'h1000, 16'h0000, 16'h0F07, 16'h1001, 16'h0000, ADDR_MP, 8'h02, 8'h42, 8'h00, 1, 1},
        '{16'hABED, 16'h0107, 16'h1000, 16'h0000, 16'h0007, 16'h0FFF, 16'h0000, ADDR_MP, 8'h42, 8'h42, 8'h00, 1, -1},
        '{16'hB3ED, 16'h0307, 16'h1000, 16'h0000, 16'h0007, 16'h1003, 16'h0000, ADDR_MP, 8'h42, 8'h42, 8'h00, 3, 1},
        '{16'hBBED, 16'h0307, 16'h1000, 16'h0000, 16'h0007, 16'h0FFD, 16'h0000, ADDR_MP, 8'h42, 8'h42, 8'h00, 3, -1},
        '{16'hB3ED, 16'h0007, 16'h1000, 16'h0000, 16'h0007, 16'h1100, 16'h0000, ADDR_MP, 8'h42, 8'h42, 8'h00, 256, 1},
        '{16'h5AD3, 16'h1234, 16'h9ABC, 16'h0000, 16'h1234, 16'h9ABC, 16'hDE5A, ADDR_MP, 8'h42, 8'hFF, 8'hDE, 1, 0},
        '{16'hE1DD, 16'h1234, 16'h9ABC, 16'h2000, 16'h1234, 16'h8485, 16'h0000, ADDR_IDX1, 8'h42, 8'hFF, 8'h00, 0, 0},
        '{16'hE1FD, 16'h1234, 16'h9ABC, 16'h30FE, 16'h1234, 16'h6A6B, 16'h0000, ADDR_IDX2, 8'h42, 8'hFF, 8'h00, 0, 0}
    };

    io_out_pop_exec #(.T_DIV(TD)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .bus_addr(bus_addr),
        .bus_dout(bus_dout), .bus_din(bus_din), .mem_rd(mem_rd), .io_wr(io_wr), .refresh(refresh),
        .refresh_row(refresh_row), .int_req(int_req), .int_ack(int_ack)
    );
    io_bus_model mem (
        .pclk(pclk), .bus_addr(bus_addr), .bus_dout(bus_dout), .mem_rd(mem_rd), .io_wr(io_wr),
        .refresh(refresh), .bus_din(bus_din)
    );

    always #2 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (int_ack === 1'b1) n_ack++;
        if (cycles == 40000) begin
            n_mismatch++;
            $display("MISMATCH t=%0t timeout", $time);
            complete_run();
        end
    end

    task complete_run;
        $display("Checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task chk_t(input int g, input int e);
        samples_checked++;
        if (g != e) begin
            n_mismatch++;
            $display("MISMATCH t=%0t spacing %0d expected %0d", $time, g, e);
        end
    endtask : chk_t

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr

    task rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0000_0000, q, e);
    endtask : rd

    task wait_idle(output logic [31:0] q);
        do begin
            rd(ADDR_CTRL, q);
        end while (q[STAT_BUSY] !== 1'b0);
    endtask : wait_idle

    task run(input row_s r);
        logic [31:0] q;
        int          n0, m0, f0;
        n0 = mem.wq.size();
        m0 = mem.mt.size();
        f0 = mem.nref;
        wr(ADDR_BC, r.bc);
        wr(ADDR_DE, 32'h0000_5678);
        wr(ADDR_MP, r.mp);
        wr(ADDR_AF, 32'h0000_DE42);
        wr(ADDR_STACK, r.sp);
        wr(ADDR_PC, 32'h0000_0100);
        wr(ADDR_INSTR, r.ins);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_idle(q);
        chk(q[STAT_DONE], 1'b1);
        chk(mem.wq.size() - n0, r.nw);
        for (int k = 0; k < r.nw; k++) begin
            if (r.stp != 0) begin
                chk(mem.wq[n0+k], {r.bc[15:8] - 8'(k + 1), r.bc[7:0], mem.byte_at(r.mp + 16'(r.stp * k))});
                chk_t(mem.wt[n0+k] - mem.mt[m0+k], 3 * TD);
                if (k > 0) chk_t(mem.wt[n0+k] - mem.wt[n0+k-1], 21 * TD);
            end else chk(mem.wq[n0+k], {r.wa, r.wd});
        end
        if (r.stp != 0) chk(mem.nref - f0, 2 * r.nw);
        rd(ADDR_BC, q);
        chk(q, r.ebc);
        rd(r.ra, q);
        chk(q, r.er);
        rd(ADDR_AF, q);
        chk(q[7:0] & r.fm, r.ef);
        rd(ADDR_PC, q);
        chk(q, 32'h0000_0102);
        if (r.ins[15:8] == OPC_POP) begin
            rd(ADDR_STACK, q);
            chk(q, r.sp + 16'h0002);
        end
        wr(ADDR_CTRL, 32'h0000_000E);
        $display("Test done: instruction %h", r.ins);
    endtask : run

    initial begin
        row_s        r;
        logic [31:0] q;
        logic        e;
        logic [7:0]  src[8];
        int          n0;
        src = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'h00, 8'hDE};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(ADDR_PC, q);
        chk(q, 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000, q, e);
        chk(q, 32'h0000_0000);
        chk(32'(e), 32'h0000_0001);
        wr(ADDR_INSTR, 32'h0000_00ED);
        wr(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_CTRL, q);
        chk(q[3:0], 4'b1000);
        wr(ADDR_CTRL, 32'h0000_000E);
        $display("Test done: reset and refusals");
        for (int i = 0; i < 8; i++) run(rows[i]);
        for (int s = 0; s < 8; s++) begin
            if (s != 6) begin
                r = '{{OUT_C_CODE | 8'(s << 3), PFX_ED}, 16'h1234, 16'h9ABC, 16'h0000, 16'h1234, 16'h9ABC,
                      16'h1234, ADDR_MP, 8'h42, 8'hFF, src[s], 1, 0};
                run(r);
            end
        end
        wr(ADDR_BC, 32'h0000_0507);
        wr(ADDR_MP, 32'h0000_1000);
        wr(ADDR_PC, 32'h0000_0100);
        wr(ADDR_INSTR, 32'h0000_B3ED);
        n0 = mem.wq.size();
        wr(ADDR_CTRL, 32'h0000_0001);
        for (int i = 0; i < 200 && mem.wq.size() == n0; i++) @(posedge pclk);
        int_req <= 1'b1;
        wait_idle(q);
        int_req <= 1'b0;
        chk(q[STAT_BRK], 1'b1);
        chk(n_ack, 1);
        chk(mem.wq.size() - n0, 1);
        rd(ADDR_BC, q);
        chk(q, 32'h0000_0407);
        rd(ADDR_PC, q);
        chk(q, 32'h0000_0100);
        wr(ADDR_CTRL, 32'h0000_000E);
        wr(ADDR_CTRL, 32'h0000_0001);
        wait_idle(q);
        rd(ADDR_BC, q);
        chk(q, 32'h0000_0007);
        rd(ADDR_MP, q);
        chk(q, 32'h0000_1005);
        $display("Test done: break and resume");
        complete_run();
    end
endmodule : test_io_out_pop_exec
`default_nettype wire
